// File: shared/bwrp_pkg.sv
package bwrp_pkg;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BWRP_ACTIVE    = 3'h0,
    BWRP_SLEEP     = 3'h1,
    BWRP_WAIT      = 3'h2,
    BWRP_BACKUP    = 3'h3,
    BWRP_WAKING    = 3'h4
  } bwrp_mode_e;

  // ----------------------------------------------------------------
  // Clock selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BWRP_CLK_MAIN  = 2'h0,
    BWRP_CLK_RC4M  = 2'h1
  } bwrp_clksel_e;

  // ----------------------------------------------------------------
  // Widths, counts and reset values
  // ----------------------------------------------------------------
  localparam int          BACKUP_REG_WORDS  = 8;
  localparam int          BACKUP_REG_HALF   = BACKUP_REG_WORDS / 2;
  localparam int          TAMPER_CNT_W      = 8;
  localparam int          DATE_W            = 32;
  localparam int          RST_CNT_W         = 8;
  localparam logic [7:0]  RST_MIN_SLOW_DEF  = 8'h04;
  localparam int          WAKE_SEQ_W        = 4;
  localparam logic [3:0]  WAKE_SEQ_CYCLES   = 4'h8;
  localparam int          RC_FREQ_MHZ       = 4;
  localparam logic [31:0] BACKUP_REG_RESET  = 32'h0000_0000;

endpackage

// File: core/bwrp_sync.sv
`timescale 1ns/1ps
module bwrp_sync (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Level in and out
  input  wire logic d,
  output logic      q
);

  logic meta;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// File: core/bwrp_top.sv
`timescale 1ns/1ps
// What this block does
// R1: Wake-up in Backup runs a sequence restoring core power and logic.
// R2: Enabled wake-up input in Wait or Sleep triggers fast start-up.
// R3: Fast start-up request is formed combinationally, without any clock.
// R4: Fast start-up restarts RC oscillator, selects 4 MHz, re-enables CPU clock.
// R5: Reset pin is bidirectional: drive low out, or be reset from outside.
// R6: External reset resets core and peripherals, never the backup region.
// R7: Any external pulse accepted; own drive lasts a guaranteed minimum. The pin is sampled on core_clk edges, so a pulse between two edges is lost.
// R8: After reset the reset pin is an input, not driven.
// R9: Tamper clears backup registers at once and takes a timestamp.
// R10: Tamper detection works in every mode, Backup included.
// R11: Each tamper stores its date and bumps a tamper count.
// R12: Option lets tamper erase only half of the backup registers.
// R13: RTC waveform output keeps running in Backup and low-power modes.
// R14: Tamper sampling may be synchronised to the RTC waveform output.
// R15: Regulator enable is 0 in Backup mode, 1 otherwise.
// R16: Entering Backup drops regulator enable; wake-up raises it again.
// R17: Regulator-off request in Active mode drives regulator enable low.
// R18: Forced wake-up pin wakes from every low-power mode.
// R19: Fast start-up request is synchronised before changing clock selection.
// R20: Minimum reset drive is a slow-clock counter with configurable length.
module bwrp_top (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         resetn,
  input  wire logic                         slow_clk_tick,
  // Mode requests from the core
  input  wire logic                         sleep_req,
  input  wire logic                         wait_req,
  input  wire logic                         backup_req,
  input  wire logic                         regulator_off_request,
  // Wake-up sources
  input  wire logic [3:0]                   wakeup_in,
  input  wire logic [3:0]                   wakeup_enable,
  input  wire logic                         forced_wakeup_pin,
  // External reset pin
  input  wire logic                         external_reset_pin_n_in,
  output logic                              external_reset_pin_n_out,
  output logic                              external_reset_pin_n_oe,
  input  wire logic                         reset_ctrl_req,
  input  wire logic [7:0]                   reset_min_slow,
  output logic                              core_periph_reset_n,
  // Tamper
  input  wire logic                         tamper_input_backup_domain,
  input  wire logic                         tamper_input_io_domain,
  input  wire logic                         tamper_sync_to_wave,
  input  wire logic                         tamper_half_erase,
  input  wire logic [31:0]                  rtc_date,
  input  wire logic                         rtc_wave_in,
  output logic                              rtc_waveform_out,
  output logic [31:0]                       tamper_date,
  output logic [7:0]                        tamper_count,
  output logic                              tamper_clear_async,
  // Backup registers
  input  wire logic                         backup_general_regs_we,
  input  wire logic [2:0]                   backup_general_regs_addr,
  input  wire logic [31:0]                  backup_general_regs_wdata,
  output logic [31:0]                       backup_general_regs_rdata,
  // Power and clock control
  output logic                              regulator_enable_out,
  output logic                              fast_startup_req,
  output logic                              rc_osc_enable,
  output logic                              cpu_clk_enable,
  output bwrp_pkg::bwrp_clksel_e            mck_select,
  output bwrp_pkg::bwrp_mode_e              mode
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Wake-up and fast start-up
  // ----------------------------------------------------------------
  logic wake_any;
  logic fsu_sync;
  logic tamper_event;

  function automatic logic low_power(input bwrp_pkg::bwrp_mode_e m);
    low_power = (m == bwrp_pkg::BWRP_SLEEP) || (m == bwrp_pkg::BWRP_WAIT) ||
                (m == bwrp_pkg::BWRP_BACKUP);
  endfunction

  assign wake_any = (|(wakeup_in & wakeup_enable)) || forced_wakeup_pin; // R18
  assign fast_startup_req = wake_any &&
                            ((mode == bwrp_pkg::BWRP_SLEEP) ||
                             (mode == bwrp_pkg::BWRP_WAIT)); // R2 R3

  bwrp_sync u_fsu_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        (fast_startup_req),
    .q        (fsu_sync)
  ); // R19

  // ----------------------------------------------------------------
  // Mode machine
  // ----------------------------------------------------------------
  bwrp_pkg::bwrp_mode_e      next_mode;
  logic [3:0]                wake_cnt;

  always_comb begin
    next_mode = mode;
    case (mode)
      bwrp_pkg::BWRP_ACTIVE: begin
        if (backup_req || regulator_off_request) begin
          next_mode = bwrp_pkg::BWRP_BACKUP;
        end else if (wait_req) begin
          next_mode = bwrp_pkg::BWRP_WAIT;
        end else if (sleep_req) begin
          next_mode = bwrp_pkg::BWRP_SLEEP;
        end
      end
      bwrp_pkg::BWRP_SLEEP, bwrp_pkg::BWRP_WAIT: begin
        if (fsu_sync) begin
          next_mode = bwrp_pkg::BWRP_ACTIVE; // R19
        end else if (backup_req) begin
          next_mode = bwrp_pkg::BWRP_BACKUP;
        end
      end
      bwrp_pkg::BWRP_BACKUP: begin
        if (wake_any) begin
          next_mode = bwrp_pkg::BWRP_WAKING; // R1 R18
        end
      end
      bwrp_pkg::BWRP_WAKING: begin
        if (wake_cnt == bwrp_pkg::WAKE_SEQ_CYCLES) begin
          next_mode = bwrp_pkg::BWRP_ACTIVE; // R1
        end
      end
      default: next_mode = bwrp_pkg::BWRP_ACTIVE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= bwrp_pkg::BWRP_ACTIVE;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt <= 4'h0;
    end else if (mode == bwrp_pkg::BWRP_WAKING) begin
      wake_cnt <= wake_cnt + 4'h1; // R1
    end else begin
      wake_cnt <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // Regulator and clocks
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regulator_enable_out <= 1'b1;
    end else begin
      regulator_enable_out <= (next_mode != bwrp_pkg::BWRP_BACKUP); // R15 R16 R17
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mck_select     <= bwrp_pkg::BWRP_CLK_MAIN;
      rc_osc_enable  <= 1'b1;
      cpu_clk_enable <= 1'b1;
    end else if (fsu_sync) begin
      mck_select     <= bwrp_pkg::BWRP_CLK_RC4M; // R4
      rc_osc_enable  <= 1'b1;
      cpu_clk_enable <= 1'b1;
    end else if (mode == bwrp_pkg::BWRP_WAKING) begin
      rc_osc_enable  <= 1'b1;
      cpu_clk_enable <= 1'b1;
    end else if (low_power(next_mode)) begin
      rc_osc_enable  <= 1'b0;
      cpu_clk_enable <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // External reset pin
  // ----------------------------------------------------------------
  logic [7:0] rst_drive_cnt;
  logic       ext_rst_s;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_drive_cnt <= 8'h00; // R8
    end else if (reset_ctrl_req && rst_drive_cnt == 8'h00) begin
      rst_drive_cnt <= (reset_min_slow == 8'h00) ? 8'h01 : reset_min_slow; // R20
    end else if (slow_clk_tick && rst_drive_cnt != 8'h00) begin
      rst_drive_cnt <= rst_drive_cnt - 8'h01; // R7 R20
    end
  end

  assign external_reset_pin_n_oe  = (rst_drive_cnt != 8'h00); // R5 R8
  assign external_reset_pin_n_out = 1'b0;

  bwrp_sync u_rst_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        (~external_reset_pin_n_in),
    .q        (ext_rst_s)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_periph_reset_n <= 1'b0;
    end else begin
      core_periph_reset_n <= ~(ext_rst_s || external_reset_pin_n_oe); // R5 R6 R7
    end
  end

  // ----------------------------------------------------------------
  // RTC waveform and tamper
  // ----------------------------------------------------------------
  logic wave_d;
  logic tmp_raw;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rtc_waveform_out <= 1'b0;
      wave_d           <= 1'b0;
    end else begin
      rtc_waveform_out <= rtc_wave_in; // R13
      wave_d           <= rtc_waveform_out;
    end
  end

  assign tmp_raw = tamper_input_backup_domain || tamper_input_io_domain; // R10
  assign tamper_clear_async = tmp_raw; // R9

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tamper_event <= 1'b0;
    end else if (!tamper_sync_to_wave || (rtc_waveform_out && !wave_d)) begin
      tamper_event <= tmp_raw && !tamper_event; // R14
    end else begin
      tamper_event <= 1'b0;
    end
  end

  // Backup state is kept by core reset only; external pin reset never touches it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tamper_date  <= 32'h0000_0000;
      tamper_count <= 8'h00;
    end else if (tamper_event) begin
      tamper_date  <= rtc_date; // R9 R11
      tamper_count <= tamper_count + 8'h01; // R11
    end
  end

  // ----------------------------------------------------------------
  // Backup registers
  // ----------------------------------------------------------------
  logic [31:0] backup_general_regs [bwrp_pkg::BACKUP_REG_WORDS];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < bwrp_pkg::BACKUP_REG_WORDS; i++) begin
        backup_general_regs[i] <= bwrp_pkg::BACKUP_REG_RESET;
      end
    end else if (tamper_event) begin
      for (int i = 0; i < bwrp_pkg::BACKUP_REG_WORDS; i++) begin
        if (!tamper_half_erase || i < bwrp_pkg::BACKUP_REG_HALF) begin
          backup_general_regs[i] <= bwrp_pkg::BACKUP_REG_RESET; // R9 R12
        end
      end
    end else if (backup_general_regs_we) begin
      backup_general_regs[backup_general_regs_addr] <= backup_general_regs_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      backup_general_regs_rdata <= 32'h0000_0000;
    end else begin
      backup_general_regs_rdata <= backup_general_regs[backup_general_regs_addr];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reg_backup_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == bwrp_pkg::BWRP_BACKUP |-> !regulator_enable_out) // R15
    else $error("regulator enabled in backup");
  a_reg_off_req: assert property (@(posedge core_clk) disable iff (!rst_n)
    regulator_off_request && mode == bwrp_pkg::BWRP_ACTIVE |=> !regulator_enable_out) // R17
    else $error("regulator off request ignored");
  a_wake_restore: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == bwrp_pkg::BWRP_BACKUP && wake_any |=> ##[1:12] regulator_enable_out) // R16
    else $error("regulator not restored after wake");
  a_fsu_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
    fast_startup_req |-> ##[1:3] mode == bwrp_pkg::BWRP_ACTIVE) // R2
    else $error("fast start-up missing");
  a_fsu_clock: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(fast_startup_req) && mode == bwrp_pkg::BWRP_SLEEP
      |-> ##[2:3] mck_select == bwrp_pkg::BWRP_CLK_RC4M && cpu_clk_enable) // R4
    else $error("clock not switched on fast start-up");
  a_fsu_synced: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(fast_startup_req) && mode == bwrp_pkg::BWRP_WAIT
      |=> mck_select == $past(mck_select)) // R19
    else $error("clock switched before sync");
  a_rst_drive_min: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(external_reset_pin_n_oe) |-> external_reset_pin_n_oe [*2]) // R7
    else $error("reset drive too short");
  a_rst_core: assert property (@(posedge core_clk) disable iff (!rst_n)
    !external_reset_pin_n_in [*3] |=> !core_periph_reset_n) // R6
    else $error("external reset not applied");
  a_tamper_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    tamper_event |=> tamper_count == $past(tamper_count) + 8'h01) // R11
    else $error("tamper count not updated");
  a_tamper_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    tamper_event |=> backup_general_regs[0] == bwrp_pkg::BACKUP_REG_RESET) // R9
    else $error("backup registers not cleared");
  a_half_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    tamper_event && tamper_half_erase |=> backup_general_regs[bwrp_pkg::BACKUP_REG_WORDS-1]
      == $past(backup_general_regs[bwrp_pkg::BACKUP_REG_WORDS-1])) // R12
    else $error("upper half erased");

endmodule

// File: tb/bwrp_partner.sv
`timescale 1ns/1ps
// ----------
// Far side: reset pin with pull-up, regulator
// ----------
module bwrp_partner (
  // Reset pin
  input  wire logic pin_out,
  input  wire logic pin_oe,
  input  wire logic ext_pull_low,
  output logic      pin_level,
  // Regulator
  input  wire logic reg_enable,
  output logic      reg_on
);
  // Pull-up holds the pin high unless a party drives it low
  assign pin_level = ((pin_oe && !pin_out) || ext_pull_low) ? 1'b0 : 1'b1;
  assign reg_on    = (reg_enable === 1'b1) ? 1'b1 : 1'b0;
endmodule

// File: tb/bwrp_bench.sv
`timescale 1ns/1ps
module bwrp_bench;
  // ----------
  // Signals
  // ----------
  logic        core_clk = 1'b0, resetn = 1'b0, slow_clk_tick = 1'b0;
  logic        sleep_req = 1'b0, wait_req = 1'b0, backup_req = 1'b0;
  logic        regulator_off_request = 1'b0, forced_wakeup_pin = 1'b0;
  logic [3:0]  wakeup_in = 4'h0, wakeup_enable = 4'h0;
  logic        reset_ctrl_req = 1'b0, ext_low = 1'b0;
  logic [7:0]  reset_min_slow = 8'h03;
  logic        tamper_input_backup_domain = 1'b0, tamper_input_io_domain = 1'b0;
  logic        tamper_sync_to_wave = 1'b0, tamper_half_erase = 1'b0, rtc_wave_in = 1'b0;
  logic [31:0] rtc_date = 32'h0, backup_general_regs_wdata = 32'h0;
  logic        backup_general_regs_we = 1'b0;
  logic [2:0]  backup_general_regs_addr = 3'h0;
  logic [1:0]  tc = 2'h0;
  logic        pin_lvl, pin_out, pin_oe, core_periph_reset_n, rtc_waveform_out;
  logic [31:0] tamper_date, backup_general_regs_rdata;
  logic [7:0]  tamper_count;
  logic        tamper_clear_async, regulator_enable_out, reg_on, fast_startup_req;
  logic        rc_osc_enable, cpu_clk_enable;
  int          errors = 0, checked = 0;
  bwrp_pkg::bwrp_clksel_e mck_select;
  bwrp_pkg::bwrp_mode_e   mode;
  localparam logic [31:0] PAT = 32'hA5C3_0010;
  // ----------
  // Clock, slow tick, partner and design
  // ----------
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    tc <= tc + 2'h1;
    slow_clk_tick <= (tc == 2'h3);
  end
  bwrp_partner far (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_pull_low(ext_low), .pin_level(pin_lvl),
    .reg_enable(regulator_enable_out), .reg_on(reg_on)
  );
  bwrp_top dut (
    .core_clk, .resetn, .slow_clk_tick, .sleep_req, .wait_req, .backup_req,
    .regulator_off_request, .wakeup_in, .wakeup_enable, .forced_wakeup_pin,
    .external_reset_pin_n_in(pin_lvl), .external_reset_pin_n_out(pin_out),
    .external_reset_pin_n_oe(pin_oe), .reset_ctrl_req, .reset_min_slow,
    .core_periph_reset_n, .tamper_input_backup_domain, .tamper_input_io_domain,
    .tamper_sync_to_wave, .tamper_half_erase, .rtc_date, .rtc_wave_in,
    .rtc_waveform_out, .tamper_date, .tamper_count, .tamper_clear_async,
    .backup_general_regs_we, .backup_general_regs_addr, .backup_general_regs_wdata,
    .backup_general_regs_rdata, .regulator_enable_out, .fast_startup_req,
    .rc_osc_enable, .cpu_clk_enable, .mck_select, .mode
  );
  // ----------
  // Tasks
  // ----------
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_mode(bwrp_pkg::bwrp_mode_e m);
    for (int i = 0; i < 40 && mode !== m; i++) @(negedge core_clk);
    chk("mode", m, mode);
    if (mode !== m) results();
  endtask
  task automatic fill;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      backup_general_regs_we <= 1'b1;
      backup_general_regs_addr <= 3'(i);
      backup_general_regs_wdata <= PAT + 32'(i);
    end
    @(posedge core_clk);
    backup_general_regs_we <= 1'b0;
  endtask
  task automatic gcheck(logic [7:0] clr);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      backup_general_regs_addr <= 3'(i);
      @(posedge core_clk);
      @(negedge core_clk);
      chk("backup_general_regs_rdata", clr[i] ? 32'h0 : PAT + 32'(i),
          backup_general_regs_rdata);
    end
  endtask
  task automatic tamper(logic io);
    @(posedge core_clk);
    if (io) tamper_input_io_domain <= 1'b1;
    else tamper_input_backup_domain <= 1'b1;
    @(negedge core_clk);
    chk("tamper_clear_async", 1'b1, tamper_clear_async);
    @(posedge core_clk);
    tamper_input_io_domain <= 1'b0;
    tamper_input_backup_domain <= 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  // ----------
  // Mode table: requests {sleep, wait, backup, off}, mode, regulator, wake
  // ----------
  typedef struct packed {
    logic [3:0]           req;
    bwrp_pkg::bwrp_mode_e m;
    logic                 reg_en;
    logic [3:0]           wk;
    logic                 fw;
  } bwrp_row_s;
  localparam bwrp_row_s ROWS [6] = '{
    '{4'h8, bwrp_pkg::BWRP_SLEEP, 1'b1, 4'h1, 1'b0},
    '{4'h4, bwrp_pkg::BWRP_WAIT, 1'b1, 4'h8, 1'b0},
    '{4'h4, bwrp_pkg::BWRP_WAIT, 1'b1, 4'h0, 1'b1},
    '{4'h2, bwrp_pkg::BWRP_BACKUP, 1'b0, 4'h0, 1'b1},
    '{4'h1, bwrp_pkg::BWRP_BACKUP, 1'b0, 4'h2, 1'b0},
    '{4'hE, bwrp_pkg::BWRP_BACKUP, 1'b0, 4'h0, 1'b1}
  };
  // ----------
  // Sequence
  // ----------
  initial begin
    int n;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk("pin_oe", 1'b0, pin_oe);
    chk("reg_on", 1'b1, reg_on);
    $display("test reset done");
    foreach (ROWS[r]) begin
      @(posedge core_clk);
      {sleep_req, wait_req, backup_req, regulator_off_request} <= ROWS[r].req;
      @(posedge core_clk);
      @(negedge core_clk);
      chk("mode", ROWS[r].m, mode);
      chk("reg_on", ROWS[r].reg_en, reg_on);
      chk("cpu_clk_enable", 1'b0, cpu_clk_enable);
      @(posedge core_clk);
      {sleep_req, wait_req, backup_req, regulator_off_request} <= 4'h0;
      wakeup_in <= ROWS[r].wk;
      wakeup_enable <= ROWS[r].wk;
      forced_wakeup_pin <= ROWS[r].fw;
      @(negedge core_clk);
      if (!ROWS[r].reg_en) wait_mode(bwrp_pkg::BWRP_WAKING);
      else chk("fast_startup_req", 1'b1, fast_startup_req);
      wait_mode(bwrp_pkg::BWRP_ACTIVE);
      chk("reg_on", 1'b1, reg_on);
      if (ROWS[r].reg_en) begin
        chk("mck_select", bwrp_pkg::BWRP_CLK_RC4M, mck_select);
        chk("rc_osc_enable", 1'b1, rc_osc_enable);
        chk("cpu_clk_enable", 1'b1, cpu_clk_enable);
      end
      @(posedge core_clk);
      wakeup_in <= 4'h0;
      forced_wakeup_pin <= 1'b0;
      $display("test row %0d done", r);
    end
    @(posedge core_clk);
    wait_req <= 1'b1;
    wakeup_in <= 4'h1;
    wakeup_enable <= 4'h2;
    @(posedge core_clk);
    wait_req <= 1'b0;
    repeat (4) @(negedge core_clk);
    chk("fast_startup_req", 1'b0, fast_startup_req);
    chk("mode", bwrp_pkg::BWRP_WAIT, mode);
    @(posedge core_clk);
    wakeup_enable <= 4'h1;
    wait_mode(bwrp_pkg::BWRP_ACTIVE);
    @(posedge core_clk);
    wakeup_in <= 4'h0;
    reset_ctrl_req <= 1'b1;
    @(posedge core_clk);
    reset_ctrl_req <= 1'b0;
    n = 0;
    for (int i = 0; i < 60; i++) begin
      @(negedge core_clk);
      if (pin_oe === 1'b1 && slow_clk_tick) n++;
      if (pin_oe === 1'b1) chk("pin_lvl", 1'b0, pin_lvl);
    end
    chk("drive_ticks", 32'(reset_min_slow), 32'(n));
    $display("test reset drive done");
    fill;
    @(posedge core_clk);
    ext_low <= 1'b1;
    @(posedge core_clk);
    ext_low <= 1'b0;
    n = 0;
    for (int i = 0; i < 30; i++) begin
      @(negedge core_clk);
      if (core_periph_reset_n === 1'b0) n++;
    end
    chk("ext_reset_seen", 1'b1, n > 0);
    chk("core_periph_reset_n", 1'b1, core_periph_reset_n);
    chk("tamper_count", 8'h00, tamper_count);
    gcheck(8'h00);
    $display("test external reset done");
    @(posedge core_clk);
    rtc_date <= 32'h1234_5678;
    tamper(1'b0);
    chk("tamper_count", 8'h01, tamper_count);
    chk("tamper_date", 32'h1234_5678, tamper_date);
    gcheck(8'hFF);
    @(posedge core_clk);
    tamper_half_erase <= 1'b1;
    rtc_date <= 32'h0BAD_0042;
    fill;
    tamper(1'b1);
    chk("tamper_count", 8'h02, tamper_count);
    chk("tamper_date", 32'h0BAD_0042, tamper_date);
    gcheck(8'h0F);
    $display("test tamper done");
    @(posedge core_clk);
    backup_req <= 1'b1;
    tamper_half_erase <= 1'b0;
    @(posedge core_clk);
    backup_req <= 1'b0;
    rtc_wave_in <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk("mode", bwrp_pkg::BWRP_BACKUP, mode);
    chk("rtc_waveform_out", 1'b1, rtc_waveform_out);
    tamper(1'b0);
    chk("tamper_count", 8'h03, tamper_count);
    @(posedge core_clk);
    rtc_wave_in <= 1'b0;
    tamper_sync_to_wave <= 1'b1;
    repeat (2) @(posedge core_clk);
    tamper_input_backup_domain <= 1'b1;
    repeat (4) @(negedge core_clk);
    chk("tamper_count", 8'h03, tamper_count);
    @(posedge core_clk);
    rtc_wave_in <= 1'b1;
    repeat (4) @(negedge core_clk);
    chk("tamper_count", 8'h04, tamper_count);
    @(posedge core_clk);
    tamper_input_backup_domain <= 1'b0;
    tamper_sync_to_wave <= 1'b0;
    forced_wakeup_pin <= 1'b1;
    wait_mode(bwrp_pkg::BWRP_ACTIVE);
    $display("test backup tamper done");
    results();
  end
endmodule
